// ### masked_reset_reg.sv
// One soft reset control register whose writes are gated bit by bit.
// Assumes wr_en is a single-cycle pulse on the committing APB edge.
`timescale 1ns/1ps
module masked_reset_reg #(
  parameter int unsigned       WIDTH   = 32,
  parameter logic [WIDTH-1:0]  IMPL    = '0,
  parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [WIDTH-1:0] cap_mask,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] value_ff;
  logic [WIDTH-1:0] nxt_value;
  logic [WIDTH-1:0] write_mask;

  always_comb begin
    // Capability and implemented bits both gate the write
    write_mask = IMPL & cap_mask;
    nxt_value  = value_ff;
    if (wr_en) begin
      nxt_value = (value_ff & ~write_mask) | (wdata & write_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_ff <= RST_VAL;
    end else begin
      value_ff <= nxt_value;
    end
  end

  assign value = value_ff;

endmodule // masked_reset_reg

// ### peripheral_soft_reset_ctrl.sv
// Top of the peripheral soft reset controller: APB slave, two gated control
// registers, capability mask capture and registered per-unit reset outputs.
// Assumes an APB3 master on pclk and static capability straps from pins.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
module peripheral_soft_reset_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] cap_two_strap,
  input  wire logic [31:0] cap_four_strap,
  output logic             two_wire_unit_reset,
  output logic             quadrature_decoder_reset,
  output logic             sync_serial_reset,
  output logic             serial_port_zero_reset,
  output logic             serial_port_one_reset,
  output logic             port_a_reset,
  output logic             port_b_reset,
  output logic             port_c_reset,
  output logic             port_d_reset,
  output logic             port_e_reset
);

  localparam int unsigned DW = soft_reset_pkg::DATA_W;
  localparam int unsigned AW = soft_reset_pkg::ADDR_W;
  localparam int unsigned NP = soft_reset_pkg::PORT_COUNT;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by the read path and the write strobes

  function automatic soft_reset_pkg::reg_sel_e decode(input logic [AW-1:0] a);
    soft_reset_pkg::reg_sel_e s;
    s = soft_reset_pkg::SEL_NONE;
    if (a == soft_reset_pkg::OFS_CTRL_ONE) begin
      s = soft_reset_pkg::SEL_CTRL_ONE;
    end else if (a == soft_reset_pkg::OFS_CTRL_TWO) begin
      s = soft_reset_pkg::SEL_CTRL_TWO;
    end else if (a == soft_reset_pkg::OFS_CAP_TWO) begin
      s = soft_reset_pkg::SEL_CAP_TWO;
    end else if (a == soft_reset_pkg::OFS_CAP_FOUR) begin
      s = soft_reset_pkg::SEL_CAP_FOUR;
    end else if (a == soft_reset_pkg::OFS_ACTIVE) begin
      s = soft_reset_pkg::SEL_ACTIVE;
    end
    return s;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus request bundle

  soft_reset_pkg::apb_req_s req;
  soft_reset_pkg::reg_sel_e req_sel;

  always_comb begin
    req.sel    = psel;
    req.enable = penable;
    req.write  = pwrite;
    req.addr   = paddr;
    req.wdata  = pwdata;
    req_sel    = decode(req.addr);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Capability masks, frozen from the straps after reset release

  logic [DW-1:0] cap_two;
  logic [DW-1:0] cap_four;
  logic          cap_two_done;
  logic          cap_four_done;

  strap_capture #(
    .WIDTH   (DW)
  ) u_cap_two (
    .pclk     (pclk),
    .presetn  (presetn),
    .strap_in (cap_two_strap),
    .captured (cap_two),
    .done     (cap_two_done)
  );

  strap_capture #(
    .WIDTH   (DW)
  ) u_cap_four (
    .pclk     (pclk),
    .presetn  (presetn),
    .strap_in (cap_four_strap),
    .captured (cap_four),
    .done     (cap_four_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // APB phase tracking: zero wait states, answer in the first access cycle

  soft_reset_pkg::apb_phase_e phase_ff;
  soft_reset_pkg::apb_phase_e nxt_phase;
  soft_reset_pkg::apb_rsp_s   rsp_ff;
  soft_reset_pkg::apb_rsp_s   nxt_rsp;
  logic                       commit;
  logic                       wr_one;
  logic                       wr_two;
  logic [DW-1:0]              ctrl_one;
  logic [DW-1:0]              ctrl_two;
  logic [DW-1:0]              active_word;

  // The commit edge is the one where the master sees pready high
  assign commit = req.sel && req.enable && rsp_ff.ready;
  assign wr_one = commit && req.write && (req_sel == soft_reset_pkg::SEL_CTRL_ONE);
  assign wr_two = commit && req.write && (req_sel == soft_reset_pkg::SEL_CTRL_TWO);

  always_comb begin
    nxt_phase     = phase_ff;
    nxt_rsp       = rsp_ff;
    nxt_rsp.ready = 1'b0;
    unique case (phase_ff)
      soft_reset_pkg::PH_IDLE: begin
        if (req.sel && !req.enable) begin
          // Setup cycle: prepare the whole answer so every output is a flop
          nxt_phase      = soft_reset_pkg::PH_ACCESS;
          nxt_rsp.ready  = 1'b1;
          nxt_rsp.slverr = (req_sel == soft_reset_pkg::SEL_NONE);
          nxt_rsp.rdata  = '0;
          if (!req.write) begin
            unique case (req_sel)
              soft_reset_pkg::SEL_CTRL_ONE: nxt_rsp.rdata = ctrl_one;
              soft_reset_pkg::SEL_CTRL_TWO: nxt_rsp.rdata = ctrl_two;
              soft_reset_pkg::SEL_CAP_TWO:  nxt_rsp.rdata = cap_two;
              soft_reset_pkg::SEL_CAP_FOUR: nxt_rsp.rdata = cap_four;
              soft_reset_pkg::SEL_ACTIVE:   nxt_rsp.rdata = active_word;
              default:                      nxt_rsp.rdata = '0;
            endcase
          end
        end
      end
      soft_reset_pkg::PH_ACCESS: begin
        if (commit) begin
          nxt_phase      = soft_reset_pkg::PH_IDLE;
          nxt_rsp.slverr = 1'b0;
          nxt_rsp.rdata  = '0;
        end else begin
          nxt_rsp.ready = 1'b1;
        end
      end
      default: begin
        nxt_phase = soft_reset_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= soft_reset_pkg::PH_IDLE;
      rsp_ff   <= '0;
    end else begin
      phase_ff <= nxt_phase;
      rsp_ff   <= nxt_rsp;
    end
  end

  assign prdata  = rsp_ff.rdata;
  assign pready  = rsp_ff.ready;
  assign pslverr = rsp_ff.slverr;

  //////////////////////////////////////////////////////////////////////////////
  // Control registers; reserved bits never store, so they read back zero

  masked_reset_reg #(
    .WIDTH   (DW),
    .IMPL    (soft_reset_pkg::IMPL_CTRL_ONE),
    .RST_VAL (soft_reset_pkg::RST_CTRL_ONE)
  ) u_ctrl_one (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_one),
    .wdata    (req.wdata),
    .cap_mask (cap_two),
    .value    (ctrl_one)
  );

  masked_reset_reg #(
    .WIDTH   (DW),
    .IMPL    (soft_reset_pkg::IMPL_CTRL_TWO),
    .RST_VAL (soft_reset_pkg::RST_CTRL_TWO)
  ) u_ctrl_two (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_en    (wr_two),
    .wdata    (req.wdata),
    .cap_mask (cap_four),
    .value    (ctrl_two)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Peripheral reset outputs, one flop each, active high

  logic          two_wire_ff;
  logic          quad_ff;
  logic          sync_ser_ff;
  logic          ser_zero_ff;
  logic          ser_one_ff;
  logic [NP-1:0] port_ff;
  logic          nxt_two_wire;
  logic          nxt_quad;
  logic          nxt_sync_ser;
  logic          nxt_ser_zero;
  logic          nxt_ser_one;
  logic [NP-1:0] nxt_port;

  always_comb begin
    nxt_two_wire = ctrl_one[soft_reset_pkg::POS_TWO_WIRE];
    nxt_quad     = ctrl_one[soft_reset_pkg::POS_QUAD];
    nxt_sync_ser = ctrl_one[soft_reset_pkg::POS_SYNC_SER];
    nxt_ser_one  = ctrl_one[soft_reset_pkg::POS_SER_ONE];
    nxt_ser_zero = ctrl_one[soft_reset_pkg::POS_SER_ZERO];
    nxt_port     = ctrl_two[soft_reset_pkg::POS_PORT_A +: NP];
  end

  // Outputs lag the register by one cycle; a unit sees reset one pclk after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_wire_ff <= 1'b0;
      quad_ff     <= 1'b0;
      sync_ser_ff <= 1'b0;
      ser_zero_ff <= 1'b0;
      ser_one_ff  <= 1'b0;
      port_ff     <= '0;
    end else begin
      two_wire_ff <= nxt_two_wire;
      quad_ff     <= nxt_quad;
      sync_ser_ff <= nxt_sync_ser;
      ser_zero_ff <= nxt_ser_zero;
      ser_one_ff  <= nxt_ser_one;
      port_ff     <= nxt_port;
    end
  end

  assign two_wire_unit_reset      = two_wire_ff;
  assign quadrature_decoder_reset = quad_ff;
  assign sync_serial_reset        = sync_ser_ff;
  assign serial_port_zero_reset   = ser_zero_ff;
  assign serial_port_one_reset    = ser_one_ff;
  assign port_a_reset             = port_ff[0];
  assign port_b_reset             = port_ff[1];
  assign port_c_reset             = port_ff[2];
  assign port_d_reset             = port_ff[3];
  assign port_e_reset             = port_ff[4];

  //////////////////////////////////////////////////////////////////////////////
  // Status word: resets actually driven, plus strap capture completion

  always_comb begin
    active_word                                        = '0;
    active_word[soft_reset_pkg::POS_TWO_WIRE]          = two_wire_ff;
    active_word[soft_reset_pkg::POS_QUAD]              = quad_ff;
    active_word[soft_reset_pkg::POS_SYNC_SER]          = sync_ser_ff;
    active_word[soft_reset_pkg::POS_SER_ONE]           = ser_one_ff;
    active_word[soft_reset_pkg::POS_SER_ZERO]          = ser_zero_ff;
    active_word[soft_reset_pkg::POS_ACT_PORTS +: NP]   = port_ff;
    active_word[DW-1]                                  = cap_two_done & cap_four_done;
  end

endmodule // peripheral_soft_reset_ctrl

// ### soft_reset_assertions.sv
// Concurrent checks for the peripheral soft reset controller.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
module soft_reset_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] cap_two_strap,
  input wire logic [31:0] cap_four_strap,
  input wire logic        two_wire_unit_reset,
  input wire logic        quadrature_decoder_reset,
  input wire logic        sync_serial_reset,
  input wire logic        serial_port_zero_reset,
  input wire logic        serial_port_one_reset,
  input wire logic        port_a_reset,
  input wire logic        port_b_reset,
  input wire logic        port_c_reset,
  input wire logic        port_d_reset,
  input wire logic        port_e_reset
);
  logic [2:0]  age_ff;
  logic [31:0] one_ff;
  logic [31:0] two_ff;
  logic        live;
  logic        wr_one;
  logic        wr_two;
  logic        rd_go;

  ////////////////////////////////////////////////////////////////////////////////
  // Shadow copies of the two registers; masks are only valid once straps froze
  assign live   = age_ff >= 3'h3;
  assign rd_go  = psel & penable & pready & ~pwrite;
  assign wr_one = psel & penable & pready & pwrite & (paddr == soft_reset_pkg::OFS_CTRL_ONE) & live;
  assign wr_two = psel & penable & pready & pwrite & (paddr == soft_reset_pkg::OFS_CTRL_TWO) & live;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_ff <= 3'h0;
      one_ff <= 32'h0;
      two_ff <= 32'h0;
    end else begin
      if (age_ff != 3'h7) age_ff <= age_ff + 3'h1;
      if (wr_one) one_ff <= ((one_ff & ~cap_two_strap) | (pwdata & cap_two_strap)) & soft_reset_pkg::IMPL_CTRL_ONE;
      if (wr_two) two_ff <= ((two_ff & ~cap_four_strap) | (pwdata & cap_four_strap)) & soft_reset_pkg::IMPL_CTRL_TWO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_two_wire; wr_one |-> ##2 (two_wire_unit_reset == one_ff[12]); endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire reset does not follow masked write");
  property p_quad; wr_one |-> ##2 (quadrature_decoder_reset == one_ff[8]); endproperty
  a_quad: assert property (p_quad) else $error("quadrature reset does not follow masked write");
  property p_sync; wr_one |-> ##2 (sync_serial_reset == one_ff[4]); endproperty
  a_sync: assert property (p_sync) else $error("sync serial reset does not follow masked write");
  property p_serial; wr_one |-> ##2 ({serial_port_one_reset, serial_port_zero_reset} == one_ff[1:0]); endproperty
  a_serial: assert property (p_serial) else $error("serial port resets do not follow masked write");
  property p_ports;
    wr_two |-> ##2 ({port_e_reset, port_d_reset, port_c_reset, port_b_reset, port_a_reset} == two_ff[4:0]);
  endproperty
  a_ports: assert property (p_ports) else $error("port resets do not follow masked write");
  property p_read_one; rd_go && (paddr == soft_reset_pkg::OFS_CTRL_ONE) |-> (prdata == one_ff); endproperty
  a_read_one: assert property (p_read_one) else $error("register one read mismatch");
  property p_read_two; rd_go && (paddr == soft_reset_pkg::OFS_CTRL_TWO) |-> (prdata == two_ff); endproperty
  a_read_two: assert property (p_read_two) else $error("register two read mismatch");
  property p_hold; $changed(port_a_reset) || $changed(two_wire_unit_reset) |-> $past(wr_one | wr_two, 2); endproperty
  a_hold: assert property (p_hold) else $error("reset output moved without a write");
  property p_clear;
    $rose(presetn) |-> ({two_wire_unit_reset, quadrature_decoder_reset, sync_serial_reset, serial_port_one_reset,
      serial_port_zero_reset, port_a_reset, port_b_reset, port_c_reset, port_d_reset, port_e_reset} == 10'h000);
  endproperty
  a_clear: assert property (p_clear) else $error("reset output high after reset");
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not a single cycle after setup");

  c_wr_one: cover property (wr_one);
  c_wr_two: cover property (wr_two);
  c_err:    cover property (pready && pslverr);
endmodule // soft_reset_assertions

bind peripheral_soft_reset_ctrl soft_reset_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cap_two_strap(cap_two_strap), .cap_four_strap(cap_four_strap),
  .two_wire_unit_reset(two_wire_unit_reset), .quadrature_decoder_reset(quadrature_decoder_reset),
  .sync_serial_reset(sync_serial_reset), .serial_port_zero_reset(serial_port_zero_reset),
  .serial_port_one_reset(serial_port_one_reset), .port_a_reset(port_a_reset), .port_b_reset(port_b_reset),
  .port_c_reset(port_c_reset), .port_d_reset(port_d_reset), .port_e_reset(port_e_reset));

// ### soft_reset_pkg.sv
// Constants, register map and carrier types for the peripheral soft reset block.
// Assumes a 32-bit APB slave on a 10 MHz pclk with an active-low asynchronous reset.
package soft_reset_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 12'h044;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 12'h048;
  localparam logic [ADDR_W-1:0] OFS_CAP_TWO  = 12'h050;
  localparam logic [ADDR_W-1:0] OFS_CAP_FOUR = 12'h054;
  localparam logic [ADDR_W-1:0] OFS_ACTIVE   = 12'h058;

  //////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned POS_TWO_WIRE   = 12;
  localparam int unsigned POS_QUAD       = 8;
  localparam int unsigned POS_SYNC_SER   = 4;
  localparam int unsigned POS_SER_ONE    = 1;
  localparam int unsigned POS_SER_ZERO   = 0;
  localparam int unsigned POS_PORT_A     = 0;
  localparam int unsigned PORT_COUNT     = 5;
  localparam int unsigned POS_ACT_PORTS  = 16;

  // Implemented (writable) bits; every other position is read-only zero
  localparam logic [DATA_W-1:0] IMPL_CTRL_ONE = 32'h0000_1113;
  localparam logic [DATA_W-1:0] IMPL_CTRL_TWO = 32'h0000_001f;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [DATA_W-1:0] RST_CTRL_ONE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CTRL_TWO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CAP      = 32'h0000_0000;

  // Synchroniser depth plus one settle cycle before straps are frozen
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_CTRL_ONE = 3'b001,
    SEL_CTRL_TWO = 3'b010,
    SEL_CAP_TWO  = 3'b011,
    SEL_CAP_FOUR = 3'b100,
    SEL_ACTIVE   = 3'b101
  } reg_sel_e;

  typedef enum logic [0:0] {
    PH_IDLE   = 1'b0,
    PH_ACCESS = 1'b1
  } apb_phase_e;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_s;

  typedef struct packed {
    logic              ready;
    logic              slverr;
    logic [DATA_W-1:0] rdata;
  } apb_rsp_s;

endpackage

// ### strap_capture.sv
// Synchronises a capability strap bus and freezes it shortly after reset release.
// Assumes the straps are static levels from outside the pclk domain.
`timescale 1ns/1ps
module strap_capture #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] strap_in,
  output logic      [WIDTH-1:0] captured,
  output logic                  done
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] cap_ff;
  logic [WIDTH-1:0] nxt_cap;
  logic [1:0]       cnt_ff;
  logic [1:0]       nxt_cnt;
  logic             done_ff;
  logic             nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_cap  = cap_ff;
    nxt_done = done_ff;
    if (!done_ff) begin
      if (cnt_ff == soft_reset_pkg::STRAP_SETTLE) begin
        nxt_cap  = sync_ff;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
      cap_ff  <= soft_reset_pkg::RST_CAP;
      cnt_ff  <= 2'h0;
      done_ff <= 1'b0;
    end else begin
      meta_ff <= strap_in;
      sync_ff <= meta_ff;
      cap_ff  <= nxt_cap;
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign captured = cap_ff;
  assign done     = done_ff;

endmodule // strap_capture

// ### testbench.sv
// Self-checking bench for the peripheral soft reset controller.
// Assumes the design files and the bound checker are compiled beforehand.
`timescale 1ns/1ps
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] cap_two_strap;
  logic [31:0] cap_four_strap;
  logic [31:0] rd;
  logic [9:0]  outs;
  int          fails;
  int          n_checks;

  peripheral_soft_reset_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cap_two_strap(cap_two_strap), .cap_four_strap(cap_four_strap), .two_wire_unit_reset(outs[9]),
    .quadrature_decoder_reset(outs[8]), .sync_serial_reset(outs[7]), .serial_port_one_reset(outs[6]),
    .serial_port_zero_reset(outs[5]), .port_e_reset(outs[4]), .port_d_reset(outs[3]),
    .port_c_reset(outs[2]), .port_b_reset(outs[1]), .port_a_reset(outs[0]));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Straps are frozen after reset, so a new mask needs a new reset
  task automatic do_reset(input logic [31:0] m2, input logic [31:0] m4);
    @(posedge pclk);
    cap_two_strap  <= m2;
    cap_four_strap <= m4;
    presetn        <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Sample pready, read data and error at the rising edge that commits the transfer
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    check({31'h0, pready}, 32'h1, "no pready");
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Outputs trail the register by one cycle
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    apb(1'b0, soft_reset_pkg::OFS_CTRL_ONE, 32'h0, rd, er);
    check(rd, 32'h0, "one after reset");
    apb(1'b0, soft_reset_pkg::OFS_CTRL_TWO, 32'h0, rd, er);
    check(rd, 32'h0, "two after reset");
    check({22'h0, outs}, 32'h0, "outputs after reset");
    $display("test reset_values done");
  endtask

  task automatic t_unit_map;
    int pos[5] = '{12, 8, 4, 1, 0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, soft_reset_pkg::OFS_CTRL_ONE, 32'h1 << pos[i], rd, er);
      settle();
      // The port bit of the previous pass is still set in register two
      check({22'h0, outs}, (32'h200 >> i) | ((32'h1 << i) >> 1), "unit map one");
      apb(1'b1, soft_reset_pkg::OFS_CTRL_TWO, 32'h1 << i, rd, er);
      settle();
      check({22'h0, outs}, (32'h200 >> i) | (32'h1 << i), "unit map two");
    end
    apb(1'b1, soft_reset_pkg::OFS_CTRL_ONE, 32'hffff_ffff, rd, er);
    apb(1'b0, soft_reset_pkg::OFS_CTRL_ONE, 32'h0, rd, er);
    check(rd, 32'h0000_1113, "one reserved bits");
    apb(1'b1, soft_reset_pkg::OFS_CTRL_TWO, 32'hffff_ffff, rd, er);
    apb(1'b0, soft_reset_pkg::OFS_CTRL_TWO, 32'h0, rd, er);
    check(rd, 32'h0000_001f, "two reserved bits");
    apb(1'b1, soft_reset_pkg::OFS_CTRL_ONE, 32'h0, rd, er);
    apb(1'b1, soft_reset_pkg::OFS_CTRL_TWO, 32'h0, rd, er);
    settle();
    check({22'h0, outs}, 32'h0, "all released");
    $display("test unit_map done");
  endtask

  task automatic t_unmapped;
    apb(1'b0, 12'h04c, 32'h0, rd, er);
    check({31'h0, er}, 32'h1, "unmapped read error");
    check(rd, 32'h0, "unmapped read data");
    apb(1'b1, 12'h040, 32'hffff_ffff, rd, er);
    check({31'h0, er}, 32'h1, "unmapped write error");
    apb(1'b0, soft_reset_pkg::OFS_CTRL_ONE, 32'h0, rd, er);
    check(rd, 32'h0, "one untouched");
    $display("test unmapped done");
  endtask

  task automatic t_masked;
    do_reset(32'h0000_1001, 32'h0000_000a);
    apb(1'b1, soft_reset_pkg::OFS_CTRL_ONE, 32'hffff_ffff, rd, er);
    apb(1'b1, soft_reset_pkg::OFS_CTRL_TWO, 32'hffff_ffff, rd, er);
    apb(1'b0, soft_reset_pkg::OFS_CTRL_ONE, 32'h0, rd, er);
    check(rd, 32'h0000_1001, "one masked");
    apb(1'b0, soft_reset_pkg::OFS_CTRL_TWO, 32'h0, rd, er);
    check(rd, 32'h0000_000a, "two masked");
    settle();
    check({22'h0, outs}, 32'h22a, "masked outputs");
    apb(1'b0, soft_reset_pkg::OFS_CAP_TWO, 32'h0, rd, er);
    check(rd, 32'h0000_1001, "cap two readback");
    apb(1'b1, soft_reset_pkg::OFS_CAP_FOUR, 32'hffff_ffff, rd, er);
    apb(1'b0, soft_reset_pkg::OFS_CAP_FOUR, 32'h0, rd, er);
    check(rd, 32'h0000_000a, "cap four readback");
    apb(1'b0, soft_reset_pkg::OFS_ACTIVE, 32'h0, rd, er);
    check(rd, 32'h800a_1001, "active word");
    $display("test masked done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    presetn        = 1'b0;
    psel           = 1'b0;
    penable        = 1'b0;
    pwrite         = 1'b0;
    paddr          = 12'h000;
    pwdata         = 32'h0;
    cap_two_strap  = 32'h0;
    cap_four_strap = 32'h0;
    do_reset(32'hffff_ffff, 32'hffff_ffff);
    t_reset_values();
    t_unit_map();
    t_unmapped();
    t_masked();
    summarize();
  end

  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    $display("FAIL %0t watchdog expired", $time);
    summarize();
  end
endmodule // testbench
